// File: verilog/uie_pkg.sv
/*
 * Shared constants and carrier types for the UART interrupt enable and
 * prioritised status block. Assumes a single core clock and a serial
 * register link that runs on its own clock.
 */
package uie_pkg;

	localparam int unsigned FILL_W = 8;

	// register addresses in the normal and the alternate (0xbf) space
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_ISR = 3'h2;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_CHR = 3'h4;

	// enable register fields
	localparam int unsigned IER_RX    = 0;
	localparam int unsigned IER_TX    = 1;
	localparam int unsigned IER_LS    = 2;
	localparam int unsigned IER_MS    = 3;
	localparam int unsigned IER_XOFF  = 5;
	localparam int unsigned IER_RTS   = 6;
	localparam int unsigned IER_CTS   = 7;
	localparam int unsigned IER_LOCKED_LO = 4;

	// line status fields
	localparam int unsigned LSR_DR   = 0;
	localparam int unsigned LSR_OVR  = 1;
	localparam int unsigned LSR_THRE = 5;
	localparam int unsigned LSR_TEMT = 6;
	localparam int unsigned LSR_FERR = 7;

	// reset values and the stale-read byte
	localparam logic [7:0] IER_RST  = 8'h00;
	localparam logic [7:0] CHAR_RST = 8'h00;
	localparam logic [7:0] ISR_RST  = 8'h01;
	localparam logic [7:0] RD_NONE  = 8'h00;
	localparam logic [7:0] RD_STALE = 8'hff;

	// status codes, index 0 is priority level 1
	localparam logic [5:0] ISR_NONE = 6'h01;
	localparam logic [5:0] ISR_CODE [7] = '{6'h06, 6'h0c, 6'h04, 6'h02,
		6'h00, 6'h10, 6'h20};

	// serial frame: command byte, data or dummy byte, read byte
	localparam int unsigned CMD_RD  = 7;
	localparam logic [4:0]  CNT_CMD = 5'd7;
	localparam logic [4:0]  CNT_WR  = 5'd15;
	localparam logic [4:0]  CNT_RD  = 5'd16;
	localparam logic [4:0]  CNT_END = 5'd24;

	typedef struct packed {
		logic [FILL_W-1:0] fill;
		logic [FILL_W-1:0] trig;
		logic              push;
		logic              push_err;
		logic              empty;
		logic              hold_full;
		logic              overrun;
		logic [2:0]        head_err;
		logic              any_err;
		logic              timeout;
	} uie_rx_stat_type;

	typedef struct packed {
		logic thr_empty;
		logic all_empty;
		logic below_trig;
		logic thr_write;
	} uie_tx_stat_type;

	typedef struct packed {
		logic fifo_en;
		logic enh_en;
		logic auto_rts;
		logic auto_cts;
		logic lsi_on_push;
		logic alt_space;
		logic gpio_space;
	} uie_mode_type;

endpackage

// File: verilog/uie_sync2.sv
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit changes slowly relative to the destination clock.
 */
`timescale 1ns/1ps
module uie_sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// File: verilog/uie_prio.sv
/*
 * Fixed-priority encoder for the interrupt status code.
 * Assumes request bit 0 is the highest priority level.
 */
`timescale 1ns/1ps
module uie_prio (
	input  wire logic [6:0] req,
	output logic      [5:0] code
);
	always_comb begin
		code = uie_pkg::ISR_NONE;
		for (int i = 6; i >= 0; i--) begin
			if (req[i]) begin
				code = uie_pkg::ISR_CODE[i];
			end
		end
	end
endmodule

// File: verilog/uie_irq_core.sv
/*
 * Interrupt enable, line status and prioritised interrupt status of a
 * single-channel UART, reached over a serial register link.
 * Assumes the FIFO, transmitter and flow-control engines run on clk and
 * report through the status structs; the link clock is foreign.
 */
`timescale 1ns/1ps
// Functional notes
// RQ1 - fifo mode: receive interrupt pends while fill is at or above trigger
// RQ2 - data-ready bit sets on each push, clears when receive fifo empties
// RQ3 - fifo on with low four enables clear gives polled mode via status
// RQ4 - line status bit 1 is a sticky overrun flag
// RQ5 - line status bits 2 to 4 show errors of the holding character
// RQ6 - bit 5 holding register empty, bit 6 fifo and shifter empty
// RQ7 - bit 7 set when any character in the receive fifo has an error
// RQ8 - enable bit 0 gates receive ready; holding-full or trigger level
// RQ9 - enable bit 1 gates transmit ready; holding empty or below trigger
// RQ10 - setting enable bit 1 with holding empty raises transmit ready
// RQ11 - enable bit 2 gates line status interrupt from bits 1 to 4
// RQ12 - overrun raises line status interrupt at once
// RQ13 - error bits interrupt at holding, or at push when mode bit set
// RQ14 - enable bit 3 gates modem status interrupt, default off
// RQ15 - enable bit 4 sleep, writable only with enhanced functions on
// RQ16 - enable bit 5 gates xoff receive interrupt, needs enhanced functions
// RQ17 - enable bit 6 gates rts rising interrupt under auto rts
// RQ18 - enable bit 7 gates cts rising interrupt under auto cts
// RQ19 - status read gives only the highest pending source in bits 0 to 5
// RQ20 - status bit 0 low while pending, high when idle and after reset
// RQ21 - source codes by priority level 1 to 7, idle code 000001
// RQ22 - interrupt output active while any enabled source pends
module uie_irq_core (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     link_sclk,
	input  wire logic                     link_cs_n,
	input  wire logic                     link_mosi,
	output logic                          link_miso,
	output logic                          link_miso_oe,
	input  wire uie_pkg::uie_mode_type    mode,
	input  wire uie_pkg::uie_rx_stat_type rx_stat,
	input  wire uie_pkg::uie_tx_stat_type tx_stat,
	input  wire logic                     modem_pending,
	input  wire logic                     xoff_seen,
	input  wire logic                     rts_out,
	input  wire logic                     cts_pin,
	input  wire logic                     msr_read,
	output logic                          irq_n,
	output logic                          sleep_en,
	output logic [31:0]                   flow_chars
);
	// ---------------- link clock domain ----------------
	logic [4:0] bit_cnt_q;
	logic [7:0] shin_q;
	logic [7:0] cmd_q;
	logic [7:0] miso_sh_q;
	logic       miso_oe_q;
	logic       req_tgl_q;
	logic       req_wr_q;
	logic [2:0] req_addr_q;
	logic [7:0] req_wdata_q;
	logic       ack_link;
	logic [7:0] byte_in;

	// ---------------- core clock domain ----------------
	logic       req_sync;
	logic       cts_sync;
	logic       req_seen_q;
	logic       ack_tgl_q;
	logic [7:0] rdata_q;
	logic [7:0] ier_q;
	logic [7:0] isr_q;
	logic       irq_n_q;
	logic [7:0] flow_q [4];
	logic [7:0] gpio_q [4];
	logic       dr_q;
	logic       ovr_q;
	logic       push_err_q;
	logic       tx_cond_q;
	logic       tx_pend_q;
	logic       xoff_pend_q;
	logic       flow_pend_q;
	logic       rts_q;
	logic       cts_q;
	logic       req_new;
	logic       wr_ier;
	logic       wr_chr;
	logic       rd_isr;
	logic       rd_lsr;
	logic       tx_cond;
	logic       tx_set;
	logic       flow_set;
	logic       head_lsi;
	logic [7:0] line_status;
	logic [6:0] pend;
	logic [5:0] code;

	assign byte_in = {shin_q[6:0], link_mosi};

	always_ff @(posedge link_sclk or posedge link_cs_n) begin
		if (link_cs_n) begin
			bit_cnt_q <= 5'd0;
		end else if (bit_cnt_q != uie_pkg::CNT_END) begin
			bit_cnt_q <= bit_cnt_q + 5'd1;
		end
	end

	always_ff @(posedge link_sclk or posedge link_cs_n) begin
		if (link_cs_n) begin
			shin_q <= 8'h00;
			cmd_q  <= 8'h00;
		end else begin
			shin_q <= byte_in;
			if (bit_cnt_q == uie_pkg::CNT_CMD) begin
				cmd_q <= byte_in;
			end
		end
	end

	// request words held stable until the core has taken the toggle
	always_ff @(posedge link_sclk or negedge rst_n) begin
		if (!rst_n) begin
			req_tgl_q   <= 1'b0;
			req_wr_q    <= 1'b0;
			req_addr_q  <= 3'h0;
			req_wdata_q <= 8'h00;
		end else if (bit_cnt_q == uie_pkg::CNT_CMD
				&& byte_in[uie_pkg::CMD_RD]) begin
			req_tgl_q  <= ~req_tgl_q;
			req_wr_q   <= 1'b0;
			req_addr_q <= byte_in[2:0];
		end else if (bit_cnt_q == uie_pkg::CNT_WR
				&& !cmd_q[uie_pkg::CMD_RD]) begin
			req_tgl_q   <= ~req_tgl_q;
			req_wr_q    <= 1'b1;
			req_addr_q  <= cmd_q[2:0];
			req_wdata_q <= byte_in;
		end
	end

	uie_sync2 #(.W(1)) u_sync_link (
		.clk   (link_sclk),
		.rst_n (rst_n),
		.d     (ack_tgl_q),
		.q     (ack_link)
	);

	// read byte leaves msb first on falling edges of the third byte
	always_ff @(negedge link_sclk or posedge link_cs_n) begin
		if (link_cs_n) begin
			miso_sh_q <= 8'h00;
			miso_oe_q <= 1'b0;
		end else if (bit_cnt_q == uie_pkg::CNT_RD
				&& cmd_q[uie_pkg::CMD_RD] && !miso_oe_q) begin
			miso_sh_q <= (ack_link == req_tgl_q) ? rdata_q
				: uie_pkg::RD_STALE;
			miso_oe_q <= 1'b1;
		end else if (miso_oe_q) begin
			miso_sh_q <= {miso_sh_q[6:0], 1'b0};
		end
	end

	assign link_miso    = miso_sh_q[7];
	assign link_miso_oe = miso_oe_q;

	// ---------------- core side of the link ----------------
	uie_sync2 #(.W(2)) u_sync_core (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({req_tgl_q, cts_pin}),
		.q     ({req_sync, cts_sync})
	);

	assign req_new = req_sync != req_seen_q;
	assign wr_ier  = req_new && req_wr_q && !mode.alt_space
		&& req_addr_q == uie_pkg::ADDR_IER;
	assign wr_chr  = req_new && req_wr_q && mode.alt_space
		&& req_addr_q[2];
	assign rd_isr  = req_new && !req_wr_q && !mode.alt_space
		&& req_addr_q == uie_pkg::ADDR_ISR;
	assign rd_lsr  = req_new && !req_wr_q && !mode.alt_space
		&& req_addr_q == uie_pkg::ADDR_LSR;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_seen_q <= 1'b0;
			ack_tgl_q  <= 1'b0;
			rdata_q    <= uie_pkg::RD_NONE;
		end else if (req_new) begin
			req_seen_q <= req_sync;
			ack_tgl_q  <= req_sync;
			if (req_wr_q) begin
				rdata_q <= rdata_q;
			end else if (mode.alt_space && req_addr_q[2]) begin
				rdata_q <= mode.gpio_space ? gpio_q[req_addr_q[1:0]]
					: flow_q[req_addr_q[1:0]];
			end else if (mode.alt_space) begin
				rdata_q <= uie_pkg::RD_NONE;
			end else begin
				case (req_addr_q)
				uie_pkg::ADDR_IER: rdata_q <= ier_q;
				uie_pkg::ADDR_ISR: rdata_q <= isr_q; // RQ19
				uie_pkg::ADDR_LSR: rdata_q <= line_status;
				default:           rdata_q <= uie_pkg::RD_NONE;
				endcase
			end
		end
	end

	// ---------------- registers ----------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ier_q <= uie_pkg::IER_RST;
		end else if (wr_ier) begin
			ier_q[3:0] <= req_wdata_q[3:0];
			if (mode.enh_en) begin
				ier_q[7:4] <= req_wdata_q[7:4]; // RQ15 RQ16
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				flow_q[i] <= uie_pkg::CHAR_RST;
				gpio_q[i] <= uie_pkg::CHAR_RST;
			end
		end else if (wr_chr) begin
			if (mode.gpio_space) begin
				gpio_q[req_addr_q[1:0]] <= req_wdata_q;
			end else begin
				flow_q[req_addr_q[1:0]] <= req_wdata_q;
			end
		end
	end

	assign sleep_en   = ier_q[uie_pkg::IER_LOCKED_LO];
	assign flow_chars = {flow_q[3], flow_q[2], flow_q[1], flow_q[0]};

	// ---------------- line status ----------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dr_q <= 1'b0;
		end else if (rx_stat.push) begin
			dr_q <= 1'b1; // RQ2
		end else if (rx_stat.empty) begin
			dr_q <= 1'b0; // RQ2
		end
	end

	// sticky error flags: a new event beats the clearing read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovr_q      <= 1'b0;
			push_err_q <= 1'b0;
		end else begin
			if (rx_stat.overrun) begin
				ovr_q <= 1'b1; // RQ4
			end else if (rd_lsr) begin
				ovr_q <= 1'b0;
			end
			if (rx_stat.push && rx_stat.push_err) begin
				push_err_q <= 1'b1;
			end else if (rd_lsr) begin
				push_err_q <= 1'b0;
			end
		end
	end

	// polled mode reads these bits directly RQ3
	assign line_status = {rx_stat.any_err, tx_stat.all_empty, // RQ7 RQ6
		tx_stat.thr_empty, rx_stat.head_err, ovr_q, dr_q}; // RQ5

	// ---------------- event flags ----------------
	assign tx_cond = mode.fifo_en ? tx_stat.below_trig
		: tx_stat.thr_empty; // RQ9
	assign tx_set  = (tx_cond && !tx_cond_q)
		|| (wr_ier && req_wdata_q[uie_pkg::IER_TX]
		&& !ier_q[uie_pkg::IER_TX] && tx_stat.thr_empty); // RQ10

	assign flow_set = (mode.auto_rts && ier_q[uie_pkg::IER_RTS]
		&& rts_out && !rts_q) // RQ17
		|| (mode.auto_cts && ier_q[uie_pkg::IER_CTS]
		&& cts_q == 1'b0 && cts_sync); // RQ18

	// empty is the idle level, so no false rise right after reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_cond_q <= 1'b1;
			rts_q     <= 1'b0;
			cts_q     <= 1'b0;
		end else begin
			tx_cond_q <= tx_cond;
			rts_q     <= rts_out;
			cts_q     <= cts_sync;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_pend_q <= 1'b0;
		end else if (tx_set) begin
			tx_pend_q <= 1'b1;
		end else if (rd_isr || tx_stat.thr_write) begin
			tx_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			xoff_pend_q <= 1'b0;
		end else if (xoff_seen) begin
			xoff_pend_q <= 1'b1;
		end else if (rd_isr) begin
			xoff_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flow_pend_q <= 1'b0;
		end else if (flow_set) begin
			flow_pend_q <= 1'b1;
		end else if (msr_read) begin
			flow_pend_q <= 1'b0;
		end
	end

	// ---------------- priority and output ----------------
	assign head_lsi = mode.lsi_on_push ? push_err_q
		: |rx_stat.head_err; // RQ13

	always_comb begin
		pend    = 7'h00;
		pend[0] = ier_q[uie_pkg::IER_LS] && (ovr_q || head_lsi); // RQ11 RQ12
		pend[1] = ier_q[uie_pkg::IER_RX] && mode.fifo_en
			&& rx_stat.timeout;
		pend[2] = ier_q[uie_pkg::IER_RX] && (mode.fifo_en // RQ8
			? rx_stat.fill >= rx_stat.trig : rx_stat.hold_full); // RQ1
		pend[3] = ier_q[uie_pkg::IER_TX] && tx_pend_q; // RQ9
		pend[4] = ier_q[uie_pkg::IER_MS] && modem_pending; // RQ14
		pend[5] = mode.enh_en && ier_q[uie_pkg::IER_XOFF]
			&& xoff_pend_q; // RQ16
		pend[6] = mode.enh_en && flow_pend_q;
	end

	uie_prio u_prio (
		.req  (pend),
		.code (code)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			isr_q   <= uie_pkg::ISR_RST; // RQ20
			irq_n_q <= 1'b1;
		end else begin
			isr_q   <= {mode.fifo_en, mode.fifo_en, code}; // RQ21 RQ19
			irq_n_q <= ~(|pend); // RQ22
		end
	end

	assign irq_n = irq_n_q;

	// ---------------- checks ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_ier_tx_rise;
		wr_ier && req_wdata_q[uie_pkg::IER_TX]
			&& !ier_q[uie_pkg::IER_TX] && tx_stat.thr_empty;
	endsequence

	sequence s_xoff_held;
		xoff_pend_q && !rd_isr;
	endsequence

	sequence s_polled;
		ier_q[3:0] == 4'h0 && !pend[5] && !pend[6];
	endsequence

	AST_RX_TRIG: assert property (mode.fifo_en && ier_q[0] && !pend[0] // RQ1
		&& !pend[1] && rx_stat.fill >= rx_stat.trig
		|=> isr_q[5:0] == 6'h04 && !irq_n)
		else $error("receive trigger not reported");
	AST_DR_PUSH: assert property (rx_stat.push |=> dr_q) // RQ2
		else $error("data ready missed a push");
	AST_POLLED: assert property (s_polled ##1 s_polled // RQ3
		|-> irq_n ##1 irq_n)
		else $error("interrupt while polled");
	AST_OVR_STICK: assert property (rx_stat.overrun // RQ4
		|=> line_status[uie_pkg::LSR_OVR] ##1 ($past(rd_lsr) || line_status[1]))
		else $error("overrun flag lost");
	AST_LSR_VIEW: assert property (rd_lsr // RQ5
		|=> rdata_q[4:2] == $past(rx_stat.head_err)
		&& rdata_q[uie_pkg::LSR_THRE] == $past(tx_stat.thr_empty)
		&& rdata_q[uie_pkg::LSR_FERR] == $past(rx_stat.any_err))
		else $error("line status view wrong");
	AST_TX_IMM: assert property (s_ier_tx_rise // RQ10
		|=> tx_pend_q ##1 (isr_q[5:0] == 6'h02
		|| $past(pend[2:0]) != 3'h0
		|| $past(rd_isr) || $past(tx_stat.thr_write)))
		else $error("transmit ready not raised on enable");
	AST_LSI_TOP: assert property (ier_q[2] && ovr_q // RQ12
		|=> isr_q[5:0] == 6'h06)
		else $error("overrun not at top priority");
	AST_IER_LOCK: assert property (wr_ier && !mode.enh_en // RQ15
		|=> ier_q[7:4] == $past(ier_q[7:4]))
		else $error("upper enables written while locked");
	AST_XOFF: assert property (s_xoff_held ##0 (mode.enh_en && ier_q[5] // RQ16
		&& pend[4:0] == 5'h00) |=> isr_q[5:0] == 6'h10)
		else $error("xoff source not reported");
	AST_IDLE: assert property (pend == 7'h00 // RQ20
		|=> isr_q[0] && irq_n ##1 ($past(pend) != 7'h00 || isr_q[0]))
		else $error("idle status wrong");
	AST_IRQ: assert property (pend != 7'h00 |=> !irq_n && !isr_q[0]) // RQ22
		else $error("interrupt output not asserted");
endmodule

// File: verif/uie_host_model.sv
/*
 * Host side of the serial register link: frames of up to three bytes,
 * msb first, data set up while the link clock is low.
 * Assumes the link clock idles low and stands still between frames.
 */
`timescale 1ns/1ps
module uie_host_model (
	output logic      link_sclk,
	output logic      link_cs_n,
	output logic      link_mosi,
	input  wire logic link_miso,
	input  wire logic link_miso_oe
);
	initial begin
		link_sclk = 1'b0;
		link_cs_n = 1'b1;
		link_mosi = 1'b0;
	end

	// read frames carry a dummy byte, write frames stop after the data
	task automatic xfer(input logic rd, input logic [2:0] addr,
		input logic [7:0] wdat, output logic [7:0] rdat);
		logic [23:0] sh;
		int          nb;
		sh = {rd, 4'h0, addr, wdat, 8'h00};
		nb = rd ? 24 : 16;
		rdat = 8'h00;
		link_cs_n = 1'b0;
		#7;
		for (int i = 0; i < nb; i++) begin
			link_mosi = sh[23-i];
			#15 link_sclk = 1'b1;
			if (i >= 16)
				rdat = {rdat[6:0], link_miso_oe ? link_miso : 1'bx};
			#15 link_sclk = 1'b0;
		end
		// released line no longer shows the last bit
		link_mosi = ~link_mosi;
		#15 link_cs_n = 1'b1;
		#120;
	endtask
endmodule

// File: verif/uie_irq_core_tb.sv
/*
 * Self-checking bench for the interrupt enable and status block.
 * Assumes the host model drives the link; status inputs come from here.
 */
`timescale 1ns/1ps
module uie_irq_core_tb;
	logic                     clk;
	logic                     rst_n;
	logic                     sclk;
	logic                     cs_n;
	logic                     mosi;
	logic                     miso;
	logic                     miso_oe;
	uie_pkg::uie_mode_type    mode;
	uie_pkg::uie_rx_stat_type rx;
	uie_pkg::uie_tx_stat_type tx;
	logic                     modem_pending;
	logic                     xoff_seen;
	logic                     rts_out;
	logic                     cts_pin;
	logic                     msr_read;
	logic                     irq_n;
	logic                     sleep_en;
	logic [31:0]              flow_chars;
	int                       n_errors;
	int                       tests_run;

	uie_irq_core dut (.clk(clk), .rst_n(rst_n), .link_sclk(sclk),
		.link_cs_n(cs_n), .link_mosi(mosi), .link_miso(miso),
		.link_miso_oe(miso_oe), .mode(mode), .rx_stat(rx), .tx_stat(tx),
		.modem_pending(modem_pending), .xoff_seen(xoff_seen),
		.rts_out(rts_out), .cts_pin(cts_pin), .msr_read(msr_read),
		.irq_n(irq_n), .sleep_en(sleep_en), .flow_chars(flow_chars));

	uie_host_model host (.link_sclk(sclk), .link_cs_n(cs_n),
		.link_mosi(mosi), .link_miso(miso), .link_miso_oe(miso_oe));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_reg(input string what, input logic [2:0] a,
		input logic [7:0] exp);
		logic [7:0] d;
		host.xfer(1'b1, a, 8'h00, d);
		chk(what, exp, d);
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		logic [7:0] d;
		host.xfer(1'b0, a, v, d);
	endtask

	task automatic settle;
		repeat (4) @(negedge clk);
	endtask

	initial begin
		#300000;
		n_errors++;
		tally_and_finish;
	end

	initial begin
		n_errors = 0;
		tests_run = 0;
		rst_n = 1'b0;
		mode = '0;
		rx = '0;
		rx.empty = 1'b1;
		rx.trig = 8'h04;
		tx = '0;
		tx.thr_empty = 1'b1;
		tx.all_empty = 1'b1;
		modem_pending = 1'b0;
		xoff_seen = 1'b0;
		rts_out = 1'b0;
		cts_pin = 1'b0;
		msr_read = 1'b0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		settle;
		chk("irq_n", 1, irq_n);
		chk("sleep_en", 0, sleep_en);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'h01);
		chk_reg("ier", uie_pkg::ADDR_IER, 8'h00);
		chk_reg("lsr", uie_pkg::ADDR_LSR, 8'h60);
		chk_reg("unmapped", 3'h0, 8'h00);
		// sleep bit locked until enhanced functions are on
		wr_reg(uie_pkg::ADDR_IER, 8'h10);
		chk("sleep_en", 0, sleep_en);
		@(negedge clk) mode.enh_en = 1'b1;
		wr_reg(uie_pkg::ADDR_IER, 8'h10);
		chk("sleep_en", 1, sleep_en);
		wr_reg(uie_pkg::ADDR_IER, 8'h00);
		// holding register already empty when tx enable is set
		wr_reg(uie_pkg::ADDR_IER, 8'h02);
		chk("irq_n", 0, irq_n);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'h02);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'h01);
		chk("irq_n", 1, irq_n);
		// non-fifo receive ready follows the holding register
		@(negedge clk) rx.hold_full = 1'b1;
		wr_reg(uie_pkg::ADDR_IER, 8'h01);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'h04);
		@(negedge clk) rx.hold_full = 1'b0;
		settle;
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'h01);
		// fifo trigger level boundary
		@(negedge clk) mode.fifo_en = 1'b1;
		rx.fill = 8'h03;
		rx.empty = 1'b0;
		rx.push = 1'b1;
		@(negedge clk) rx.push = 1'b0;
		wr_reg(uie_pkg::ADDR_IER, 8'h01);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc1);
		@(negedge clk) rx.fill = 8'h04;
		settle;
		chk("irq_n", 0, irq_n);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc4);
		@(negedge clk) rx.timeout = 1'b1;
		settle;
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hcc);
		@(negedge clk) rx.timeout = 1'b0;
		// overrun outranks receive ready
		wr_reg(uie_pkg::ADDR_IER, 8'h05);
		@(negedge clk) rx.overrun = 1'b1;
		@(negedge clk) rx.overrun = 1'b0;
		settle;
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc6);
		chk_reg("lsr", uie_pkg::ADDR_LSR, 8'h63);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc4);
		@(negedge clk) rx.head_err = 3'b101;
		rx.any_err = 1'b1;
		settle;
		chk_reg("lsr", uie_pkg::ADDR_LSR, 8'hf5);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc6);
		@(negedge clk) rx.head_err = 3'b000;
		rx.any_err = 1'b0;
		// polled mode: level pending but no line raised
		wr_reg(uie_pkg::ADDR_IER, 8'h00);
		chk("irq_n", 1, irq_n);
		chk_reg("lsr", uie_pkg::ADDR_LSR, 8'h61);
		@(negedge clk) rx.fill = 8'h03;
		rx.empty = 1'b1;
		settle;
		chk_reg("lsr", uie_pkg::ADDR_LSR, 8'h60);
		@(negedge clk) rx.push = 1'b1;
		rx.empty = 1'b0;
		@(negedge clk) rx.push = 1'b0;
		settle;
		chk_reg("lsr", uie_pkg::ADDR_LSR, 8'h61);
		// errors flagged at push in the enhanced mode
		@(negedge clk) mode.lsi_on_push = 1'b1;
		wr_reg(uie_pkg::ADDR_IER, 8'h04);
		@(negedge clk) rx.push = 1'b1;
		rx.push_err = 1'b1;
		@(negedge clk) rx.push = 1'b0;
		rx.push_err = 1'b0;
		settle;
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc6);
		chk_reg("lsr", uie_pkg::ADDR_LSR, 8'h61);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc1);
		// modem status source
		@(negedge clk) modem_pending = 1'b1;
		wr_reg(uie_pkg::ADDR_IER, 8'h08);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc0);
		@(negedge clk) modem_pending = 1'b0;
		// xoff source, cleared by the status read
		wr_reg(uie_pkg::ADDR_IER, 8'h20);
		@(negedge clk) xoff_seen = 1'b1;
		@(negedge clk) xoff_seen = 1'b0;
		settle;
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hd0);
		chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc1);
		// rts then cts rising edges, cleared by modem status read
		for (int i = 0; i < 2; i++) begin
			@(negedge clk) mode.auto_rts = (i == 0);
			mode.auto_cts = (i == 1);
			wr_reg(uie_pkg::ADDR_IER, (i == 0) ? 8'h40 : 8'h80);
			@(negedge clk) rts_out = (i == 0);
			cts_pin = (i == 1);
			settle;
			chk_reg("isr", uie_pkg::ADDR_ISR, 8'he0);
			@(negedge clk) msr_read = 1'b1;
			@(negedge clk) msr_read = 1'b0;
			settle;
			chk_reg("isr", uie_pkg::ADDR_ISR, 8'hc1);
		end
		// character registers in the alternate space
		@(negedge clk) mode.alt_space = 1'b1;
		for (int a = 4; a < 8; a++)
			wr_reg(a[2:0], 8'h11 * (a - 3));
		chk("flow_chars", 32'h44332211, flow_chars);
		chk_reg("pause_a", 3'h6, 8'h33);
		@(negedge clk) mode.gpio_space = 1'b1;
		wr_reg(3'h4, 8'h5a);
		chk_reg("gpio_mask", 3'h4, 8'h5a);
		@(negedge clk) mode.gpio_space = 1'b0;
		chk_reg("resume_a", 3'h4, 8'h11);
		tally_and_finish;
	end
endmodule
